// ==== dv/gpc_ext_pins.sv ====
// Outside circuitry on the main port pins
`default_nettype none
module gpc_ext_pins (
  input  wire logic       clk_sys,
  input  wire logic [7:0] pin_out, pin_oe, pin_pullup, ext_val, ext_en,
  output var  logic [7:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] flt_r = 8'h5a;
  // Undriven lines without pull-up wander every cycle
  always @(posedge clk_sys) flt_r <= ~pin_lvl;
  // Port driver first, then outside driver, then pull-up or wander
  always_comb pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                      | (~pin_oe & ~ext_en & (pin_pullup | flt_r));
endmodule // gpc_ext_pins
`default_nettype wire

// ==== dv/gpc_port_properties.sv ====
// Concurrent checks on the port block's bus and pin outputs
`default_nettype none
module gpc_port_props #(
  parameter WIDTH = 8
) (
  input wire logic             clk_sys, rst_n, warm_rst_n, sleep_mode, wake_req,
  input wire logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic             s_axi_rvalid, s_axi_rready,
  input wire logic             shared_reset_input_pin, external_reset_pin_enable,
  input wire logic [7:0]       s_axi_araddr,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [WIDTH-1:0] pin_oe, pin_pullup
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  // ============================================================
  // Pin side
  a_pullup_inputs_only: assert property ((pin_pullup & pin_oe) == '0)
    else $error("pull-up on while pin drives");
  a_warm_floats_pins: assert property (!warm_rst_n |=> pin_oe == '0 && !wake_req)
    else $error("pin driven after warm reset");
  a_wake_in_sleep: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake request outside sleep");
  // ============================================================
  // Register bus
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while stalled");
  a_upper_bits_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_in_dir_const: assert property (ar_take && s_axi_araddr == 8'h20 |=> s_axi_rdata == 32'h8)
    else $error("input-only direction wrong");
  a_in_level_bit: assert property (ar_take && s_axi_araddr == 8'h1c |=> s_axi_rdata ==
    {28'h0, $past(shared_reset_input_pin) & !$past(external_reset_pin_enable), 3'h0})
    else $error("input-only level wrong");
  c_wake: cover property (wake_req);
  c_write_stall: cover property (s_axi_bvalid && !s_axi_bready);
  c_read_level: cover property (ar_take && s_axi_araddr == 8'h1c);
endmodule // gpc_port_props
`default_nettype wire

// ==== dv/tb.sv ====
// Bench for the port block: bus master, pin drivers and register model
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = '0, rst_n = '0, warm_rst_n = 1'h1, sleep_mode = '0;
  logic        shared_reset_input_pin = '0, external_reset_pin_enable = '0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0, m_flg;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, ext_val = '0, ext_en = 8'hff;
  logic [31:0] s_axi_wdata = '0, seed = 32'h6421, rd_d;
  logic [3:0]  s_axi_wstrb = '0;
  logic [1:0]  rsp;
  logic [7:0]  m [6];
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_req;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [7:0]  pin_in, pin_out, pin_oe, pin_pullup;
  int          n_errors = 0, checks = 0;
  // Clock, design and outside pins
  always #12.5 clk_sys = ~clk_sys;
  gpc_port gpc_port_inst (.clk_sys, .rst_n, .warm_rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pin_pullup,
    .shared_reset_input_pin, .external_reset_pin_enable, .sleep_mode, .wake_req);
  gpc_ext_pins gpc_ext_pins_inst (.clk_sys, .pin_out, .pin_oe, .pin_pullup, .ext_val, .ext_en,
    .pin_lvl(pin_in));
  // ============================================================
  // Model: m = latch, direction, analog, pull-up, change enable, option
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] lvl();
    return (~m[1] & m[0]) | (m[1] & ext_en & ext_val) | (m[1] & ~ext_en & m[3] & {8{~m[5][7]}});
  endfunction
  function automatic logic [31:0] exp_rd(logic [7:0] a);
    if (a == 8'h00) return {24'h0, lvl() & ~m[2]};
    if (a < 8'h18) return {24'h0, m[a[4:2]]};
    if (a == 8'h18) return {31'h0, m_flg};
    if (a == 8'h1c) return {28'h0, shared_reset_input_pin & ~external_reset_pin_enable, 3'h0};
    return a == 8'h20 ? 32'h8 : 32'h0;
  endfunction
  task automatic mreset();
    m = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h80};
    m_flg = 1'h0;
  endtask
  // ============================================================
  // Compare, verdict and bus cycles
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (n == 2) s_axi_bready <= 1'h1;
    end
    s_axi_bready <= 1'h0;
    rsp = s_axi_bresp;
    if (n == 50) begin
      chk("bvalid", 0, 1);
      tally_and_finish();
    end
  endtask
  task automatic mr(input logic [7:0] a);
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (n == 1) s_axi_rready <= 1'h1;
    end
    s_axi_rready <= 1'h0;
    if (n == 50) begin
      chk("rvalid", 0, 1);
      tally_and_finish();
    end
    chk("rresp", s_axi_rresp, a > 8'h20 ? 32'h2 : 32'h0);
    chk("rdata", s_axi_rdata, exp_rd(a));
  endtask
  task automatic mw(input logic [7:0] a, input logic [7:0] d);
    wr(a, {24'h0, d}, 4'h1);
    chk("bresp", rsp, a > 8'h20 ? 32'h2 : 32'h0);
    if (a < 8'h18) m[a[4:2]] = d;
    if (a == 8'h18 && !d[0]) m_flg = 1'h0;
  endtask
  task automatic pins(input logic [7:0] oe, input logic [7:0] pu);
    repeat (2) @(posedge clk_sys);
    chk("pin_oe", pin_oe, oe);
    chk("pin_out", pin_out, m[0]);
    chk("pin_pullup", pin_pullup, pu);
  endtask
  // ============================================================
  // Main sequence
  initial begin
    mreset();
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    for (int a = 0; a <= 36; a += 4) mr(a[7:0]);
    mw(8'h24, 8'hff);
    wr(8'h04, 32'h0, 4'h0);
    mr(8'h04);
    $display("test reset_values done");
    repeat (8) begin
      seed = lfsr(seed);
      ext_val <= seed[7:0];
      mw(8'h08, seed[15:8]);
      mw(8'h04, seed[23:16] | seed[15:8]);
      mw(8'h00, seed[31:24]);
      pins(~m[1], 8'h00);
      mr(8'h00);
      m[0] = lvl() & ~m[2];
      wr(8'h00, 32'h0, 4'h0);
      pins(~m[1], 8'h00);
    end
    mw(8'h04, 8'h00);
    mw(8'h00, 8'ha5);
    pins(8'hff, 8'h00);
    mr(8'h00);
    $display("test drive_and_read done");
    ext_en <= 8'h0f;
    mw(8'h08, 8'h00);
    mw(8'h0c, 8'hff);
    mw(8'h04, 8'h3c);
    mw(8'h14, 8'h00);
    pins(8'hc3, 8'h3c);
    mr(8'h00);
    mw(8'h14, 8'h80);
    pins(8'hc3, 8'h00);
    ext_en <= 8'hff;
    ext_val <= 8'h00;
    mw(8'h04, 8'hff);
    mw(8'h10, 8'hff);
    mr(8'h00);
    mw(8'h18, 8'h00);
    mr(8'h18);
    ext_val <= 8'h01;
    sleep_mode <= 1'h1;
    repeat (6) @(posedge clk_sys);
    chk("wake_req", wake_req, 1);
    m_flg = 1'h1;
    mr(8'h18);
    mw(8'h18, 8'h00);
    m_flg = 1'h1;
    mr(8'h18);
    mr(8'h00);
    mw(8'h18, 8'h00);
    mr(8'h18);
    chk("wake_req", wake_req, 0);
    sleep_mode <= 1'h0;
    ext_val <= 8'h02;
    repeat (6) @(posedge clk_sys);
    mw(8'h00, 8'h00);
    mw(8'h18, 8'h00);
    mr(8'h18);
    // Pin change lands in the very cycle the data read is taken
    fork
      mr(8'h00);
      begin
        @(posedge clk_sys);
        ext_val <= 8'h06;
      end
    join
    m_flg = 1'h1;
    mr(8'h18);
    warm_rst_n <= 1'h0;
    @(posedge clk_sys);
    warm_rst_n <= 1'h1;
    mreset();
    mw(8'h08, 8'h00);
    mw(8'h10, 8'hff);
    repeat (6) @(posedge clk_sys);
    mr(8'h18);
    $display("test change_flag done");
    for (int i = 0; i < 4; i++) begin
      {shared_reset_input_pin, external_reset_pin_enable} <= i[1:0];
      repeat (3) @(posedge clk_sys);
      mr(8'h1c);
      mr(8'h20);
    end
    $display("test input_only done");
    tally_and_finish();
  end
endmodule // tb
bind gpc_port gpc_port_props #(.WIDTH(WIDTH)) gpc_port_props_inst (.clk_sys, .rst_n,
  .warm_rst_n, .sleep_mode, .wake_req, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .shared_reset_input_pin, .external_reset_pin_enable, .s_axi_araddr,
  .s_axi_rdata, .pin_oe, .pin_pullup);
`default_nettype wire

// ==== hdl/gpc_change_det.v ====
// Change detector: reference latch and mismatch compare for the main port
`include "gpc_map.vh"
`default_nettype none

module gpc_change_det #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             por_n,
  input  wire             ref_load,
  input  wire [WIDTH-1:0] pin_level,
  input  wire [WIDTH-1:0] chg_en,
  output wire             mismatch
);

  reg [WIDTH-1:0] ref_r;

  // ==========================================================
  // Reference latch
  // Only the power-on reset clears it; warm resets never reach here
  always @(posedge clk_sys) begin
    if (!por_n) begin
      ref_r <= `GPC_RST_REF;
    end else if (ref_load) begin
      ref_r <= pin_level;
    end
  end

  // Compare against the old reference, so a change in a load cycle still counts
  assign mismatch = |((pin_level ^ ref_r) & chg_en);

endmodule // gpc_change_det

`default_nettype wire

// ==== hdl/gpc_map.vh ====
// Register map, field positions and reset values for the port block
`ifndef GPC_MAP_VH
`define GPC_MAP_VH

// ============================================================
// Register byte offsets
`define GPC_OFS_DATA      8'h00
`define GPC_OFS_DIR       8'h04
`define GPC_OFS_ANSEL     8'h08
`define GPC_OFS_PULLUP    8'h0c
`define GPC_OFS_CHG_EN    8'h10
`define GPC_OFS_OPTION    8'h14
`define GPC_OFS_INTCTL    8'h18
`define GPC_OFS_IN_LEVEL  8'h1c
`define GPC_OFS_IN_DIR    8'h20

// ============================================================
// Field positions
`define GPC_BIT_PU_DIS    7
`define GPC_BIT_CHG_FLAG  0
`define GPC_BIT_SHARED    3

// ============================================================
// Reset values
`define GPC_RST_DATA      8'h00
`define GPC_RST_DIR       8'hff
`define GPC_RST_ANSEL     8'hff
`define GPC_RST_PULLUP    8'h00
`define GPC_RST_CHG_EN    8'h00
`define GPC_RST_PU_DIS    1'b1
`define GPC_RST_REF       8'h00

// ============================================================
// Bus answers
`define GPC_RESP_OKAY     2'b00
`define GPC_RESP_SLVERR   2'b10

`endif

// ==== hdl/gpc_port.v ====
// Port block top: 8-bit I/O port, input-only pin, change flag, AXI4-Lite slave
//
// Overview of operation
// - Eight bidirectional pins, direction and latch each
// - Direction 1 floats pin, 0 drives latch
// - Data read gives pins, write sets latch
// - Port writes merge sampled pins into latch
// - Direction bits still drive analog-selected pins
// - Analog-selected pins read zero digitally
// - Analog select leaves digital output untouched
// - Per-pin weak pull-up enable, eight bits
// - Pull-up off whenever pin is output
// - Power-on sets global pull-up disable
// - Per-pin change enables, cleared at power-on
// - Enabled pins versus reference, ORed into flag
// - Set change flag wakes device from sleep
// - Mismatch keeps setting flag until port accessed
// - Warm resets leave reference latch alone
// - Change during port read still sets flag
// - Input-only pin at bit 3, direction reads 1
// - Input-only pin reads 0 when reset-enabled
// - Unused input-only port bits read zero
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`include "gpc_map.vh"
`default_nettype none

module gpc_port #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             warm_rst_n,
  // AXI4-Lite write address
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // Main port pins
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_out,
  output reg  [WIDTH-1:0] pin_oe,
  output reg  [WIDTH-1:0] pin_pullup,
  // Input-only pin and its configuration
  input  wire             shared_reset_input_pin,
  input  wire             external_reset_pin_enable,
  // Sleep and wake
  input  wire             sleep_mode,
  output reg              wake_req
);

  // ==========================================================
  // Declarations
  reg  [WIDTH-1:0] latch_r;
  reg  [WIDTH-1:0] dir_r;
  reg  [WIDTH-1:0] ansel_r;
  reg  [WIDTH-1:0] pullup_en_r;
  reg  [WIDTH-1:0] chg_en_r;
  reg              pu_dis_r;
  reg              chg_flag_r;
  reg              chg_flag_nxt;
  reg  [7:0]       awaddr_r;
  reg  [31:0]      wdata_r;
  reg  [3:0]       wstrb_r;
  reg              aw_have_r;
  reg              w_have_r;
  reg  [31:0]      rd_val;
  reg              rd_hit;
  wire             por_n;
  wire             any_rst_n;
  wire [WIDTH-1:0] pin_digital;
  wire             in_level;
  wire             aw_take;
  wire             w_take;
  wire             ar_take;
  wire             wr_go;
  wire             wr_hit;
  wire             wr_data;
  wire             rd_data;
  wire             mismatch;

  assign por_n     = rst_n;
  assign any_rst_n = rst_n & warm_rst_n;

  // ==========================================================
  // Input views
  // Analog-selected pins read zero whatever their level
  assign pin_digital = pin_in & ~ansel_r;
  // Input-only pin is hidden while it serves as the reset pin
  assign in_level = shared_reset_input_pin & ~external_reset_pin_enable;

  // ==========================================================
  // Bus handshakes
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign wr_go   = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_hit  = is_mapped(awaddr_r);
  assign wr_data = wr_go & (awaddr_r == `GPC_OFS_DATA);
  assign rd_data = ar_take & (s_axi_araddr == `GPC_OFS_DATA);

  // Address decode for the write path; the read path decodes in its own case
  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr == `GPC_OFS_DATA)   | (addr == `GPC_OFS_DIR)      |
                  (addr == `GPC_OFS_ANSEL)  | (addr == `GPC_OFS_PULLUP)   |
                  (addr == `GPC_OFS_CHG_EN) | (addr == `GPC_OFS_OPTION)   |
                  (addr == `GPC_OFS_INTCTL) | (addr == `GPC_OFS_IN_LEVEL) |
                  (addr == `GPC_OFS_IN_DIR);
    end
  endfunction

  // Byte-lane merge: lanes not strobed keep the given old value
  function [WIDTH-1:0] lane_merge;
    input [WIDTH-1:0] old_val;
    input [31:0]      data;
    input [3:0]       strb;
    begin
      lane_merge = strb[0] ? data[WIDTH-1:0] : old_val;
    end
  endfunction

  // ==========================================================
  // Write address and data capture, in either order
  always @(posedge clk_sys) begin
    if (!any_rst_n) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      if (aw_take) begin
        aw_have_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (w_take) begin
        w_have_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
      // Reopen both channels once the response is taken
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Write response
  always @(posedge clk_sys) begin
    if (!any_rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GPC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Configuration registers
  always @(posedge clk_sys) begin
    if (!any_rst_n) begin
      latch_r     <= `GPC_RST_DATA;
      dir_r       <= `GPC_RST_DIR;
      ansel_r     <= `GPC_RST_ANSEL;
      pullup_en_r <= `GPC_RST_PULLUP;
      chg_en_r    <= `GPC_RST_CHG_EN;
      pu_dis_r    <= `GPC_RST_PU_DIS;
    end else if (wr_go) begin
      case (awaddr_r)
        `GPC_OFS_DATA: begin
          // Pins are sampled; unstrobed lane writes them back as read
          latch_r <= lane_merge(pin_digital, wdata_r, wstrb_r);
        end
        `GPC_OFS_DIR: begin
          dir_r <= lane_merge(dir_r, wdata_r, wstrb_r);
        end
        `GPC_OFS_ANSEL: begin
          ansel_r <= lane_merge(ansel_r, wdata_r, wstrb_r);
        end
        `GPC_OFS_PULLUP: begin
          pullup_en_r <= lane_merge(pullup_en_r, wdata_r, wstrb_r);
        end
        `GPC_OFS_CHG_EN: begin
          chg_en_r <= lane_merge(chg_en_r, wdata_r, wstrb_r);
        end
        `GPC_OFS_OPTION: begin
          if (wstrb_r[0]) begin
            pu_dis_r <= wdata_r[`GPC_BIT_PU_DIS];
          end
        end
        default: begin
          latch_r <= latch_r;
        end
      endcase
    end
  end

  // ==========================================================
  // Change detector; any data access reloads its reference
  gpc_change_det #(
    .WIDTH (WIDTH)
  ) u_change_det (
    .clk_sys   (clk_sys),
    .por_n     (por_n),
    .ref_load  (rd_data | wr_data),
    .pin_level (pin_digital),
    .chg_en    (chg_en_r),
    .mismatch  (mismatch)
  );

  // ==========================================================
  // Change flag: set wins over a software clear in the same cycle
  always @* begin
    chg_flag_nxt = chg_flag_r;
    if (wr_go & (awaddr_r == `GPC_OFS_INTCTL) & wstrb_r[0]) begin
      chg_flag_nxt = wdata_r[`GPC_BIT_CHG_FLAG] & chg_flag_r;
    end
    if (mismatch) begin
      chg_flag_nxt = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (!any_rst_n) begin
      // The flag stays clear after a warm reset until chg_en_r is written again, as it clears too
      chg_flag_r <= 1'b0;
    end else begin
      chg_flag_r <= chg_flag_nxt;
    end
  end

  // ==========================================================
  // Read path
  always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `GPC_OFS_DATA: begin
        rd_val[WIDTH-1:0] = pin_digital;
      end
      `GPC_OFS_DIR: begin
        rd_val[WIDTH-1:0] = dir_r;
      end
      `GPC_OFS_ANSEL: begin
        rd_val[WIDTH-1:0] = ansel_r;
      end
      `GPC_OFS_PULLUP: begin
        rd_val[WIDTH-1:0] = pullup_en_r;
      end
      `GPC_OFS_CHG_EN: begin
        rd_val[WIDTH-1:0] = chg_en_r;
      end
      `GPC_OFS_OPTION: begin
        rd_val[`GPC_BIT_PU_DIS] = pu_dis_r;
      end
      `GPC_OFS_INTCTL: begin
        rd_val[`GPC_BIT_CHG_FLAG] = chg_flag_r;
      end
      `GPC_OFS_IN_LEVEL: begin
        rd_val[`GPC_BIT_SHARED] = in_level;
      end
      `GPC_OFS_IN_DIR: begin
        rd_val[`GPC_BIT_SHARED] = 1'b1;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Read address and data channels
  always @(posedge clk_sys) begin
    if (!any_rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `GPC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Pin drivers; analog select plays no part here
  always @(posedge clk_sys) begin
    if (!any_rst_n) begin
      pin_out    <= `GPC_RST_DATA;
      pin_oe     <= ~`GPC_RST_DIR;
      pin_pullup <= `GPC_RST_PULLUP;
    end else begin
      pin_out    <= latch_r;
      pin_oe     <= ~dir_r;
      pin_pullup <= pullup_en_r & dir_r & {WIDTH{~pu_dis_r}};
    end
  end

  // ==========================================================
  // Wake request while asleep with the change flag up
  always @(posedge clk_sys) begin
    if (!any_rst_n) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= sleep_mode & chg_flag_nxt;
    end
  end

endmodule // gpc_port

`default_nettype wire
